/* shared/ips_pkg.sv */
package ips_pkg;

    // ****************************************
    // Addressing
    // ****************************************
    localparam logic [4:0] ADDR_FIXED = 5'h06;
    localparam logic [6:0] GEN_CALL_ADDR = 7'h00;
    localparam logic [7:0] PAGE_REG = 8'h00;
    localparam logic [7:0] PAGE_RESET = 8'h00;
    localparam logic [3:0] BYTE_BITS = 4'h8;

    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_KHZ = 100000;
    localparam int STD_KHZ = 100;
    localparam int FAST_KHZ = 400;
    // A bus period is a least time, so each quarter rounds up.
    localparam int QTR_STD = (CLK_KHZ + 4 * STD_KHZ - 1) / (4 * STD_KHZ);
    localparam int QTR_FAST = (CLK_KHZ + 4 * FAST_KHZ - 1) / (4 * FAST_KHZ);

    // ****************************************
    // Master sequence steps
    // ****************************************
    localparam logic [2:0] STEP_WR_STOP = 3'h4;
    localparam logic [2:0] STEP_RD_STOP = 3'h6;

    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_ADDR = 3'b001,
        S_AACK = 3'b010,
        S_WR = 3'b011,
        S_WACK = 3'b100,
        S_RD = 3'b101,
        S_RACK = 3'b110
    } ips_slv_state_t;

    typedef enum logic [1:0] {
        K_START = 2'b00,
        K_TX = 2'b01,
        K_RX = 2'b10,
        K_STOP = 2'b11
    } ips_kind_t;

endpackage : ips_pkg

/* shared/ips_if.sv */
`timescale 1ns/10ps
interface ips_if;
    logic scl_o_m;
    logic scl_oe_m;
    logic sda_o_m;
    logic sda_oe_m;
    logic sda_o_s;
    logic sda_oe_s;
    logic scl;
    logic sda;

    // Open-drain wires: any enabled low driver wins, otherwise pull-up.
    assign scl = ~(scl_oe_m & ~scl_o_m);
    assign sda = ~((sda_oe_m & ~sda_o_m) | (sda_oe_s & ~sda_o_s));

    modport slave (input scl, input sda, output sda_o_s, output sda_oe_s);
    modport master (
        input scl,
        input sda,
        output scl_o_m,
        output scl_oe_m,
        output sda_o_m,
        output sda_oe_m
    );
endinterface : ips_if

/* core/ips_sync.sv */
`timescale 1ns/10ps
module ips_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '1
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // Data
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] meta;

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            meta <= RST_VAL;
            sync_out <= RST_VAL;
        end else begin
            meta <= async_in;
            sync_out <= meta;
        end
    end
endmodule : ips_sync

/* core/ips_slave_end.sv */
// Notes on behaviour
// - Works at 100 kHz and 400 kHz.
// - Address is 00110 plus two strap pins.
// - Slave only, never drives clock line.
// - Lines are only pulled low or released.
// - Bits change on clock low, sampled high.
// - Start and stop seen while clock high.
// - Master sends address plus direction bit.
// - Slave acknowledges each received byte.
// - Master not-acknowledges the one byte it reads.
// - Not-acknowledge leaves data high; foreign address.
// - Start inside a frame restarts address phase.
// - General call address zero is acknowledged.
// - Write data auto-increments register pointer.
// - Acknowledged read continues with next register.
// - Registers are eight bits, sent MSB first.
// - Master uses only pages 0,1,4,5,32-47.
// - Writing register zero selects the page.
// - Register zero exists in every page.
`timescale 1ns/10ps
module ips_slave_end
    import ips_pkg::*;
#(
    parameter int PAGE_BITS = 6
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // Address straps
    input wire logic addr_strap_hi,
    input wire logic addr_strap_lo,
    // Two-wire bus
    ips_if.slave bus,
    // Register file side
    output logic [7:0] cur_page,
    output logic wr_stb,
    output logic [7:0] wr_reg,
    output logic [7:0] wr_data,
    output logic busy
);

    // ****************************************
    // Pin sampling
    // ****************************************
    logic [3:0] pins_s;
    logic scl_s;
    logic sda_s;
    logic scl_d;
    logic sda_d;
    logic [6:0] own_addr;
    logic rise;
    logic fall;
    logic start_seen;
    logic stop_seen;

    ips_sync #(
        .W(4),
        .RST_VAL(4'hF)
    ) u_sync (
        .mclk(mclk),
        .resetn(resetn),
        .async_in({bus.scl, bus.sda, addr_strap_hi, addr_strap_lo}),
        .sync_out(pins_s)
    );

    assign scl_s = pins_s[3];
    assign sda_s = pins_s[2];
    assign own_addr = {ADDR_FIXED, pins_s[1:0]};

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            scl_d <= scl_s;
            sda_d <= sda_s;
        end
    end

    assign rise = scl_s & ~scl_d;
    assign fall = ~scl_s & scl_d;
    assign start_seen = scl_s & scl_d & sda_d & ~sda_s;
    assign stop_seen = scl_s & scl_d & ~sda_d & sda_s;

    // ****************************************
    // Register storage
    // ****************************************
    // Stored bytes are not reset; software writes before it reads.
    logic [7:0] mem [0:(1 << (PAGE_BITS + 8)) - 1];
    logic mem_we;
    logic [PAGE_BITS+7:0] mem_wa;
    logic [7:0] mem_wd;

    function automatic logic [7:0] reg_value(
        input logic [7:0] pg,
        input logic [7:0] idx
    );
        if (idx == PAGE_REG) begin
            return pg;
        end
        return mem[{pg[PAGE_BITS-1:0], idx}];
    endfunction : reg_value

    always_ff @(posedge mclk) begin
        if (mem_we) begin
            mem[mem_wa] <= mem_wd;
        end
    end

    // ****************************************
    // Protocol engine
    // ****************************************
    ips_slv_state_t state;
    ips_slv_state_t next_state;
    logic [3:0] cnt;
    logic [3:0] next_cnt;
    logic [7:0] sh;
    logic [7:0] next_sh;
    logic [7:0] ptr;
    logic [7:0] next_ptr;
    logic [7:0] next_cur_page;
    logic first;
    logic next_first;
    logic rd;
    logic next_rd;
    logic gc;
    logic next_gc;
    logic acked;
    logic next_acked;
    logic sda_oe;
    logic next_sda_oe;
    logic next_wr_stb;
    logic [7:0] next_wr_reg;
    logic [7:0] next_wr_data;
    logic [7:0] rd_byte;

    always_comb begin
        next_state = state;
        next_cnt = cnt;
        next_sh = sh;
        next_ptr = ptr;
        next_cur_page = cur_page;
        next_first = first;
        next_rd = rd;
        next_gc = gc;
        next_acked = acked;
        next_sda_oe = sda_oe;
        next_wr_stb = 1'b0;
        next_wr_reg = wr_reg;
        next_wr_data = wr_data;
        mem_we = 1'b0;
        mem_wa = {cur_page[PAGE_BITS-1:0], ptr};
        mem_wd = sh;
        rd_byte = 8'h00;
        if (stop_seen) begin
            next_state = S_IDLE;
            next_sda_oe = 1'b0;
        end else if (start_seen) begin
            next_state = S_ADDR;
            next_cnt = 4'h0;
            next_sda_oe = 1'b0;
            next_first = 1'b1;
        end else begin
            case (state)
                S_IDLE: begin
                    next_sda_oe = 1'b0;
                end
                S_ADDR, S_WR: begin
                    if (rise && cnt < BYTE_BITS) begin
                        next_sh = {sh[6:0], sda_s};
                        next_cnt = 4'(cnt + 4'h1);
                    end else if (fall && cnt == BYTE_BITS) begin
                        next_cnt = 4'h0;
                        if (state == S_ADDR) begin
                            if (sh[7:1] == own_addr
                                    || sh == {GEN_CALL_ADDR, 1'b0}) begin
                                next_state = S_AACK;
                                next_sda_oe = 1'b1;
                                next_rd = sh[0];
                                next_gc = (sh[7:1] == GEN_CALL_ADDR);
                            end else begin
                                next_state = S_IDLE;
                            end
                        end else begin
                            next_state = S_WACK;
                            next_sda_oe = 1'b1;
                            if (!gc && first) begin
                                next_ptr = sh;
                                next_first = 1'b0;
                            end else if (!gc) begin
                                if (ptr == PAGE_REG) begin
                                    next_cur_page = sh;
                                end else begin
                                    mem_we = 1'b1;
                                end
                                next_wr_stb = 1'b1;
                                next_wr_reg = ptr;
                                next_wr_data = sh;
                                next_ptr = 8'(ptr + 8'h01);
                            end
                        end
                    end
                end
                S_AACK: begin
                    if (fall && rd) begin
                        rd_byte = reg_value(cur_page, ptr);
                        next_state = S_RD;
                        next_sh = rd_byte;
                        next_sda_oe = ~rd_byte[7];
                    end else if (fall) begin
                        next_state = S_WR;
                        next_sda_oe = 1'b0;
                    end
                end
                S_WACK: begin
                    if (fall) begin
                        next_state = S_WR;
                        next_sda_oe = 1'b0;
                    end
                end
                S_RD: begin
                    if (fall && cnt == BYTE_BITS - 4'h1) begin
                        next_state = S_RACK;
                        next_sda_oe = 1'b0;
                        next_cnt = 4'h0;
                    end else if (fall) begin
                        next_sh = {sh[6:0], 1'b0};
                        next_sda_oe = ~sh[6];
                        next_cnt = 4'(cnt + 4'h1);
                    end
                end
                S_RACK: begin
                    if (rise) begin
                        next_acked = ~sda_s;
                    end else if (fall && acked) begin
                        rd_byte = reg_value(cur_page, 8'(ptr + 8'h01));
                        next_ptr = 8'(ptr + 8'h01);
                        next_state = S_RD;
                        next_sh = rd_byte;
                        next_sda_oe = ~rd_byte[7];
                    end else if (fall) begin
                        next_state = S_IDLE;
                    end
                end
                default: begin
                    next_state = S_IDLE;
                    next_sda_oe = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            state <= S_IDLE;
            cnt <= 4'h0;
            sh <= 8'h00;
            ptr <= 8'h00;
            cur_page <= PAGE_RESET;
            first <= 1'b1;
            rd <= 1'b0;
            gc <= 1'b0;
            acked <= 1'b0;
            sda_oe <= 1'b0;
            wr_stb <= 1'b0;
            wr_reg <= 8'h00;
            wr_data <= 8'h00;
            busy <= 1'b0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            sh <= next_sh;
            ptr <= next_ptr;
            cur_page <= next_cur_page;
            first <= next_first;
            rd <= next_rd;
            gc <= next_gc;
            acked <= next_acked;
            sda_oe <= next_sda_oe;
            wr_stb <= next_wr_stb;
            wr_reg <= next_wr_reg;
            wr_data <= next_wr_data;
            busy <= (next_state != S_IDLE);
        end
    end

    // ****************************************
    // Bus drive
    // ****************************************
    // The clock line is never touched, so the slave cannot stretch it.
    assign bus.sda_o_s = 1'b0;
    assign bus.sda_oe_s = sda_oe;

endmodule : ips_slave_end

/* core/ips_master_end.sv */
`timescale 1ns/10ps
module ips_master_end
    import ips_pkg::*;
#(
    parameter int QTR = QTR_FAST
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // Command
    input wire logic cmd_valid,
    input wire logic cmd_rd,
    input wire logic [6:0] cmd_addr,
    input wire logic [7:0] cmd_reg,
    input wire logic [7:0] cmd_data,
    output logic cmd_ready,
    // Response
    output logic rsp_valid,
    output logic [7:0] rsp_data,
    output logic rsp_nack,
    // Two-wire bus
    ips_if.master bus
);

    // ****************************************
    // Sequence decode
    // ****************************************
    function automatic ips_kind_t step_kind(
        input logic rd,
        input logic [2:0] s
    );
        if (s == 3'h0 || (rd && s == 3'h3)) begin
            return K_START;
        end
        if (s == (rd ? STEP_RD_STOP : STEP_WR_STOP)) begin
            return K_STOP;
        end
        if (rd && s == 3'h5) begin
            return K_RX;
        end
        return K_TX;
    endfunction : step_kind

    function automatic logic [7:0] tx_byte(
        input logic [6:0] a,
        input logic [7:0] r,
        input logic [7:0] d,
        input logic [2:0] s
    );
        case (s)
            3'h1: return {a, 1'b0};
            3'h2: return r;
            3'h3: return d;
            default: return {a, 1'b1};
        endcase
    endfunction : tx_byte

    // ****************************************
    // Engine
    // ****************************************
    logic sda_s;
    logic run;
    logic next_run;
    logic [2:0] step;
    logic [2:0] next_step;
    logic [1:0] q;
    logic [1:0] next_q;
    logic [15:0] qcnt;
    logic [15:0] next_qcnt;
    logic [3:0] bitn;
    logic [3:0] next_bitn;
    logic [7:0] txsh;
    logic [7:0] next_txsh;
    logic [7:0] rxsh;
    logic [7:0] next_rxsh;
    logic ackbit;
    logic next_ackbit;
    logic lrd;
    logic next_lrd;
    logic [6:0] laddr;
    logic [6:0] next_laddr;
    logic [7:0] lreg;
    logic [7:0] next_lreg;
    logic [7:0] ldata;
    logic [7:0] next_ldata;
    logic scl_oe;
    logic next_scl_oe;
    logic sda_oe;
    logic next_sda_oe;
    logic next_cmd_ready;
    logic next_rsp_valid;
    logic [7:0] next_rsp_data;
    logic next_rsp_nack;
    logic tick;
    ips_kind_t kind;

    ips_sync #(
        .W(1),
        .RST_VAL(1'b1)
    ) u_sync (
        .mclk(mclk),
        .resetn(resetn),
        .async_in(bus.sda),
        .sync_out(sda_s)
    );

    assign tick = (qcnt == 16'(QTR - 1));
    assign kind = step_kind(lrd, step);

    always_comb begin
        next_run = run;
        next_step = step;
        next_q = q;
        next_qcnt = run ? (tick ? 16'h0000 : 16'(qcnt + 16'h0001)) : 16'h0000;
        next_bitn = bitn;
        next_txsh = txsh;
        next_rxsh = rxsh;
        next_ackbit = ackbit;
        next_lrd = lrd;
        next_laddr = laddr;
        next_lreg = lreg;
        next_ldata = ldata;
        next_scl_oe = scl_oe;
        next_sda_oe = sda_oe;
        next_cmd_ready = cmd_ready;
        next_rsp_valid = 1'b0;
        next_rsp_data = rsp_data;
        next_rsp_nack = rsp_nack;
        if (!run) begin
            if (cmd_valid && cmd_ready) begin
                next_run = 1'b1;
                next_cmd_ready = 1'b0;
                next_step = 3'h0;
                next_q = 2'h0;
                next_lrd = cmd_rd;
                next_laddr = cmd_addr;
                next_lreg = cmd_reg;
                next_ldata = cmd_data;
                next_rsp_nack = 1'b0;
            end
        end else if (tick) begin
            next_q = 2'(q + 2'h1);
            case (kind)
                K_START: begin
                    case (q)
                        2'h0: next_sda_oe = 1'b0;
                        2'h1: next_scl_oe = 1'b0;
                        2'h2: next_sda_oe = 1'b1;
                        default: begin
                            next_scl_oe = 1'b1;
                            next_step = 3'(step + 3'h1);
                            next_bitn = 4'h0;
                            next_txsh = tx_byte(laddr, lreg, ldata, next_step);
                        end
                    endcase
                end
                K_STOP: begin
                    case (q)
                        2'h0: begin
                            next_scl_oe = 1'b1;
                            next_sda_oe = 1'b1;
                        end
                        2'h1: next_scl_oe = 1'b0;
                        2'h2: next_sda_oe = 1'b0;
                        default: begin
                            next_run = 1'b0;
                            next_cmd_ready = 1'b1;
                            next_rsp_valid = 1'b1;
                            next_rsp_data = rxsh;
                        end
                    endcase
                end
                default: begin
                    case (q)
                        2'h0: begin
                            // Reads release for data and for the final NACK.
                            next_sda_oe = (kind == K_TX) && (bitn < BYTE_BITS)
                                && !txsh[7];
                        end
                        2'h1: next_scl_oe = 1'b0;
                        2'h2: begin
                            if (bitn < BYTE_BITS) begin
                                next_rxsh = {rxsh[6:0], sda_s};
                            end else begin
                                next_ackbit = sda_s;
                            end
                        end
                        default: begin
                            next_scl_oe = 1'b1;
                            next_txsh = {txsh[6:0], 1'b0};
                            next_bitn = 4'(bitn + 4'h1);
                            if (bitn == BYTE_BITS && kind == K_TX
                                    && ackbit) begin
                                next_rsp_nack = 1'b1;
                                next_step = lrd ? STEP_RD_STOP : STEP_WR_STOP;
                            end else if (bitn == BYTE_BITS) begin
                                next_step = 3'(step + 3'h1);
                                next_bitn = 4'h0;
                                next_txsh = tx_byte(laddr, lreg, ldata,
                                    next_step);
                            end
                        end
                    endcase
                end
            endcase
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            run <= 1'b0;
            step <= 3'h0;
            q <= 2'h0;
            qcnt <= 16'h0000;
            bitn <= 4'h0;
            txsh <= 8'h00;
            rxsh <= 8'h00;
            ackbit <= 1'b1;
            lrd <= 1'b0;
            laddr <= 7'h00;
            lreg <= 8'h00;
            ldata <= 8'h00;
            scl_oe <= 1'b0;
            sda_oe <= 1'b0;
            cmd_ready <= 1'b1;
            rsp_valid <= 1'b0;
            rsp_data <= 8'h00;
            rsp_nack <= 1'b0;
        end else begin
            run <= next_run;
            step <= next_step;
            q <= next_q;
            qcnt <= next_qcnt;
            bitn <= next_bitn;
            txsh <= next_txsh;
            rxsh <= next_rxsh;
            ackbit <= next_ackbit;
            lrd <= next_lrd;
            laddr <= next_laddr;
            lreg <= next_lreg;
            ldata <= next_ldata;
            scl_oe <= next_scl_oe;
            sda_oe <= next_sda_oe;
            cmd_ready <= next_cmd_ready;
            rsp_valid <= next_rsp_valid;
            rsp_data <= next_rsp_data;
            rsp_nack <= next_rsp_nack;
        end
    end

    assign bus.scl_o_m = 1'b0;
    assign bus.scl_oe_m = scl_oe;
    assign bus.sda_o_m = 1'b0;
    assign bus.sda_oe_m = sda_oe;

endmodule : ips_master_end

/* tb/ips_asserts.sv */
`timescale 1ns/10ps
module ips_asserts (
    // Clock and reset
    input wire logic mclk,
    input wire logic resetn,
    // Master drivers
    input wire logic scl_o_m,
    input wire logic scl_oe_m,
    input wire logic sda_o_m,
    input wire logic sda_oe_m,
    // Slave drivers
    input wire logic sda_o_s,
    input wire logic sda_oe_s,
    // Resolved wires
    input wire logic scl,
    input wire logic sda
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!resetn);

    // **********
    // Wire rules
    // **********
    chk_slave_low_only: assert property (!sda_o_s)
        else $error("slave would drive data high");
    chk_master_low_only: assert property (!scl_o_m && !sda_o_m)
        else $error("master would drive a line high");
    chk_clock_master_only: assert property (scl == !scl_oe_m)
        else $error("clock line pulled by someone but the master");
    chk_slave_moves_low: assert property ($changed(sda_oe_s) |-> !scl)
        else $error("slave changed data while clock high");
    chk_slave_bit_hold: assert property ($rose(sda_oe_s) |-> sda_oe_s [*8])
        else $error("slave low drive too short");
    // Both may pull low together while the clock is low around an
    // acknowledge; that is harmless on open-drain wires.
    chk_one_data_owner: assert property (!(sda_oe_s && sda_oe_m && scl))
        else $error("both ends drive data at once");
    chk_start_quiet: assert property (
        $fell(sda) && scl |=> !sda_oe_s [*8])
        else $error("slave drove data right after a start");
    chk_stop_released: assert property (
        $rose(sda) && scl |=> !sda_oe_s [*8])
        else $error("slave drives data at a stop");

    // Main traffic is seen at least once.
    cover property ($rose(sda_oe_s));
    cover property ($fell(sda) && scl);
    cover property ($rose(sda) && scl);
endmodule : ips_asserts

/* tb/testbench.sv */
`timescale 1ns/10ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin err_count++; \
    $display("mismatch at %0t: got %h exp %h", $time, a, b); end end
module testbench;
    import ips_pkg::*;
    logic mclk, resetn, addr_strap_hi, addr_strap_lo, cmd_valid, cmd_rd;
    logic [6:0] cmd_addr, dev;
    logic [7:0] cmd_reg, cmd_data, rsp_data, cur_page, wr_reg, wr_data;
    logic cmd_ready, rsp_valid, rsp_nack, wr_stb, busy;
    int err_count, check_count, stb_count;

    assign dev = {ADDR_FIXED, addr_strap_hi, addr_strap_lo};
    ips_if ips_if_i ();
    // Short quarter keeps the run brief and still gives the slave 8 clocks.
    ips_master_end #(.QTR(8)) ips_master_end_i (.mclk, .resetn, .cmd_valid,
        .cmd_rd, .cmd_addr, .cmd_reg, .cmd_data, .cmd_ready, .rsp_valid,
        .rsp_data, .rsp_nack, .bus(ips_if_i.master));
    ips_slave_end ips_slave_end_i (.mclk, .resetn, .addr_strap_hi,
        .addr_strap_lo, .bus(ips_if_i.slave), .cur_page, .wr_stb, .wr_reg,
        .wr_data, .busy);
    ips_asserts ips_asserts_i (.mclk, .resetn,
        .scl_o_m(ips_if_i.scl_o_m), .scl_oe_m(ips_if_i.scl_oe_m),
        .sda_o_m(ips_if_i.sda_o_m), .sda_oe_m(ips_if_i.sda_oe_m),
        .sda_o_s(ips_if_i.sda_o_s), .sda_oe_s(ips_if_i.sda_oe_s),
        .scl(ips_if_i.scl), .sda(ips_if_i.sda));

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        if (wr_stb === 1'b1) stb_count++;
    end

    // **********
    // Helpers
    // **********
    task automatic end_of_test;
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : end_of_test

    task automatic cmd(input logic rd, input logic [6:0] a,
                       input logic [7:0] r, input logic [7:0] d);
        @(negedge mclk);
        cmd_valid = 1'b1;
        cmd_rd = rd;
        cmd_addr = a;
        cmd_reg = r;
        cmd_data = d;
        // Ready only moves on rising edges, so the falling edge shows
        // the value that the next rising edge takes.
        while (cmd_ready !== 1'b1) @(negedge mclk);
        @(negedge mclk);
        cmd_valid = 1'b0;
        while (rsp_valid !== 1'b1) @(negedge mclk);
        @(negedge mclk);
        `CHK(busy, 1'b0)
    endtask : cmd

    // **********
    // Scenarios
    // **********
    task automatic t_page;
        cmd(1'b0, dev, 8'h00, 8'h05);
        `CHK(rsp_nack, 1'b0)
        `CHK(wr_reg, 8'h00)
        `CHK(cur_page, 8'h05)
        cmd(1'b0, dev, 8'h00, 8'h21);
        `CHK(cur_page, 8'h21)
        cmd(1'b1, dev, 8'h00, 8'h00);
        `CHK(rsp_data, 8'h21)
    endtask : t_page

    task automatic t_paged_rw;
        cmd(1'b0, dev, 8'h05, 8'hAA);
        `CHK(wr_reg, 8'h05)
        `CHK(wr_data, 8'hAA)
        cmd(1'b0, dev, 8'h00, 8'h04);
        cmd(1'b0, dev, 8'h05, 8'h1E);
        cmd(1'b0, dev, 8'h00, 8'h21);
        cmd(1'b1, dev, 8'h05, 8'h00);
        `CHK(rsp_data, 8'hAA)
        cmd(1'b0, dev, 8'h00, 8'h04);
        cmd(1'b1, dev, 8'h05, 8'h00);
        `CHK(rsp_data, 8'h1E)
        `CHK(rsp_nack, 1'b0)
    endtask : t_paged_rw

    task automatic t_addr;
        int n;
        for (int i = 0; i < 4; i++) begin
            @(negedge mclk);
            {addr_strap_hi, addr_strap_lo} = 2'(i);
            repeat (4) @(negedge mclk);
            n = stb_count;
            cmd(1'b0, {ADDR_FIXED, 2'(i)}, 8'h07, 8'h40);
            `CHK(rsp_nack, 1'b0)
            `CHK(stb_count, n + 1)
            cmd(1'b0, {ADDR_FIXED, 2'(i + 1)}, 8'h07, 8'h41);
            `CHK(rsp_nack, 1'b1)
            `CHK(stb_count, n + 1)
        end
    endtask : t_addr

    task automatic t_gcall;
        int n;
        n = stb_count;
        cmd(1'b0, 7'h00, 8'h00, 8'h33);
        `CHK(rsp_nack, 1'b0)
        `CHK(stb_count, n)
        `CHK(cur_page, 8'h04)
    endtask : t_gcall

    initial begin
        resetn = 1'b0;
        addr_strap_hi = 1'b1;
        addr_strap_lo = 1'b0;
        cmd_valid = 1'b0;
        cmd_rd = 1'b0;
        cmd_addr = 7'h00;
        cmd_reg = 8'h00;
        cmd_data = 8'h00;
        repeat (8) @(negedge mclk);
        resetn = 1'b1;
        repeat (4) @(negedge mclk);
        t_page();
        t_paged_rw();
        t_addr();
        t_gcall();
        end_of_test();
    end

    // About twenty commands of under 1300 cycles each fit well inside this.
    initial begin
        #600000;
        err_count++;
        end_of_test();
    end
endmodule : testbench
